/* lrap_host_model.sv */
// Behavioural model of the 8-bit host processor on the 80-style strobe bus.
// Assumes the port samples pins asynchronously; strobes change at the falling core edge.
`timescale 1ns/10ps
module lrap_host_model (
  // Clock used only to pace the strobes.
  input wire logic core_clk_i,
  // Bus pins driven toward the port.
  output logic cs_n_o,
  output logic register_select_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [7:0] host_data_o,
  // Read data and drive enable from the port.
  input wire logic [7:0] host_data_i,
  input wire logic host_data_oe_i
);
  // Strobe and gap length in core cycles, kept above the synchroniser needs.
  localparam int HOLD = 10;

  // Idle bus at time zero.
  initial begin
    cs_n_o = 1'b1;
    register_select_o = 1'b0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    host_data_o = 8'h00;
  end

  // One strobe; read data and enable are taken just before the strobe ends.
  task automatic access(input logic rs, input logic is_rd, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic oe);
    @(negedge core_clk_i);
    cs_n_o = 1'b0;
    register_select_o = rs;
    wr_n_o = is_rd;
    rd_n_o = !is_rd;
    if (!is_rd) begin
      host_data_o = wdata;
    end
    repeat (HOLD) @(negedge core_clk_i);
    rdata = host_data_i;
    oe = host_data_oe_i;
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    // Write data is held past the strobe, since the port takes it at the filtered strobe end.
    repeat (HOLD / 2) @(negedge core_clk_i);
    // Released lines then show the inverse so a stale value is never mistaken for data.
    host_data_o = ~host_data_o;
    repeat (HOLD / 2) @(negedge core_clk_i);
  endtask
endmodule // lrap_host_model

/* lrap_host_port.sv */
// Summary of operation
// [R1] Chip select and register select low: index.
// [R2] Host writes index, then accesses data register.
// [R3] Index value held until rewritten.
// [R4] Only the RAM window is readable.
// [R5] Host writes zero to unused bits.
// [R6] Host loads column and row, then window.
// [R7] Host RAM access independent of display clock.
// [R8] Window read returns previously latched value.
// [R9] Pointer advances after window access.
// [R10] Step bit 0: row advances to 7f.
// [R11] Rows above 4f ignored.
// [R12] Step bit 1: column advances to limit.
// [R13] Column wraps to zero past limit.
// [R14] Host has priority over refresh reads.
// [R15] Host leaves minimum gap between accesses.
// [R16] Normal mode advances after read and write.
// [R17] Read-modify-write holds pointer after read.
// [R18] Host does dummy read every RMW cycle.
// [R19] Six-bit words store data lines five..zero.
// [R20] Byte holds four pixels, odd lines MSB.
// [R21] Column limit 27 or 35 by word length.
// [R22] RMW mode is a control bit.
//
// Host side of a grey-scale LCD driver: 80-style strobes into an index register,
// a control register, pointer registers and a RAM data window over a 54x80 byte RAM.
// Assumes host pins are asynchronous to core_clk_i and the host respects access spacing.
`timescale 1ns/10ps
module lrap_host_port
  import lrap_pkg::*;
#(
  parameter int ROWS = 80,
  parameter int COLS = 54
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Host bus pins, strobes active low.
  input wire logic cs_n_i,
  input wire logic register_select_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  // Display refresh read port.
  input wire logic refresh_req_i,
  input wire logic [6:0] refresh_row_i,
  input wire logic [5:0] refresh_col_i,
  output logic refresh_ack_o,
  output logic [7:0] refresh_data_o,
  // Observation of control state.
  output logic step_dir_o,
  output logic word_length_select_o,
  output logic rmw_mode_o
);
  `include "lrap_params.svh"

  // Filtered host pin levels.
  logic cs_n_s;
  logic rs_s;
  logic wr_n_s;
  logic rd_n_s;
  logic [7:0] data_s;
  // Strobes pass the filter inverted, so the filter's reset level is an idle bus.
  // Without this a false access would follow every reset.
  logic cs_s;
  logic wr_s;
  logic rd_s;

  // All state of the port except the RAM and the pin synchroniser in one packed struct.
  typedef struct packed {
    lrap_phase_t phase;
    logic is_wr;
    logic [7:0] index;
    logic [2:0] ctrl;
    logic [5:0] col;
    logic [6:0] row;
    logic [7:0] latch;
    logic [7:0] dout;
    logic [7:0] rdata;
    logic rack;
  } lrap_st_t;
  lrap_st_t st_r;
  lrap_st_t st_nxt;

  // The RAM itself, flip-flops addressed by a flat index.
  logic [7:0] mem_r [ROWS*COLS];

  // Flat RAM index of a column and row.
  function automatic int unsigned ram_idx(input logic [5:0] c, input logic [6:0] r);
    return int'(r) * COLS + int'(c);
  endfunction

  // True when the location is backed by real memory.
  function automatic logic ram_ok(input logic [5:0] c, input logic [6:0] r);
    return (r <= `LRAP_ROW_VALID_MAX) && (int'(c) < COLS); // R11
  endfunction

  // Column limit for the current word length.
  function automatic logic [5:0] col_lim(input logic word_length_select);
    return word_length_select ? `LRAP_COL_MAX_6BIT : `LRAP_COL_MAX_8BIT; // R21
  endfunction

  // Synchronise every host pin; three flops and agreement filtering.
  lrap_sync3 #(
    .W(12)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .async_i({~cs_n_i, register_select_i, ~wr_n_i, ~rd_n_i, host_data_i}), // R7
    .level_o({cs_s, rs_s, wr_s, rd_s, data_s})
  );
  assign cs_n_s = !cs_s;
  assign wr_n_s = !wr_s;
  assign rd_n_s = !rd_s;

  // Strobe starts and ends as seen after filtering.
  logic act_s;
  logic acc_end;
  logic win_sel;
  logic host_ram_use;
  logic [7:0] wdata;
  logic step;
  assign act_s = !cs_n_s && (!wr_n_s || !rd_n_s);
  assign acc_end = (st_r.phase == LRAP_ACT) && !act_s;
  assign win_sel = rs_s && (st_r.index == `LRAP_IDX_WIN);
  // The host claims the RAM on the closing edge of a window write.
  assign host_ram_use = acc_end && win_sel && st_r.is_wr; // R14
  // Six-bit words drop the two top data lines; bit pairs stay as written.
  assign wdata = st_r.ctrl[`LRAP_CTRL_WLS_BIT] ? (data_s & `LRAP_MASK_6BIT) : data_s; // R19 R20

  // Next-state logic: register writes, window reads and pointer stepping.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rack = 1'b0;
    step = 1'b0;
    unique case (st_r.phase)
      LRAP_IDLE: begin
        if (act_s) begin
          st_nxt.phase = LRAP_ACT;
          st_nxt.is_wr = !wr_n_s;
          // Present the previously latched byte on a window read.
          if (!wr_n_s == 1'b0 && rs_s && st_r.index == `LRAP_IDX_WIN) begin
            st_nxt.dout = st_r.latch; // R8 R4
          end
        end
      end
      LRAP_ACT: begin
        if (!act_s) begin
          st_nxt.phase = LRAP_IDLE;
          if (st_r.is_wr && !rs_s) begin
            st_nxt.index = data_s; // R1 R3
          end else if (st_r.is_wr) begin
            // Data register writes; unknown numbers are dropped.
            if (st_r.index == `LRAP_IDX_CTRL) begin
              st_nxt.ctrl = data_s[2:0]; // R22
            end else if (st_r.index == `LRAP_IDX_COL) begin
              st_nxt.col = data_s[5:0];
            end else if (st_r.index == `LRAP_IDX_ROW) begin
              st_nxt.row = data_s[6:0];
            end else if (st_r.index == `LRAP_IDX_WIN) begin
              step = 1'b1; // R16
            end
          end else if (win_sel) begin
            // Latch the current location for the next read.
            st_nxt.latch = ram_ok(st_r.col, st_r.row) ?
              mem_r[ram_idx(st_r.col, st_r.row)] : 8'h00; // R8
            step = !st_r.ctrl[`LRAP_CTRL_RMW_BIT]; // R17 R16
          end
        end
      end
    endcase
    // Pointer advance after a window access.
    if (step) begin // R9
      if (!st_r.ctrl[`LRAP_CTRL_STEP_BIT]) begin
        st_nxt.row = (st_r.row == `LRAP_ROW_MAX) ? `LRAP_ROW_RESET : st_r.row + 7'h01; // R10
      end else begin
        // Column wraps so a long burst rewrites the same row.
        st_nxt.col = (st_r.col >= col_lim(st_r.ctrl[`LRAP_CTRL_WLS_BIT])) ?
          `LRAP_COL_RESET : st_r.col + 6'h01; // R12 R13
      end
    end
    // Refresh reads take the RAM only in cycles the host leaves free.
    if (refresh_req_i && !host_ram_use) begin // R14
      st_nxt.rack = 1'b1;
      st_nxt.rdata = ram_ok(refresh_col_i, refresh_row_i) ?
        mem_r[ram_idx(refresh_col_i, refresh_row_i)] : 8'h00;
    end
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '{phase: LRAP_IDLE, is_wr: 1'b0, index: `LRAP_IDX_RESET,
                ctrl: `LRAP_CTRL_RESET, col: `LRAP_COL_RESET, row: `LRAP_ROW_RESET,
                latch: 8'h00, dout: 8'h00, rdata: 8'h00, rack: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // RAM write port; rows beyond the real memory are silently dropped.
  always_ff @(posedge core_clk_i) begin
    if (host_ram_use && ram_ok(st_r.col, st_r.row)) begin // R11
      mem_r[ram_idx(st_r.col, st_r.row)] <= wdata;
    end
  end

  // Read data drives only during a window read with the strobe held.
  assign host_data_o = st_r.dout;
  // The enable follows the filtered pins, so no raw pin reaches an output.
  assign host_data_oe_o = !cs_n_s && !rd_n_s && win_sel; // R4
  assign refresh_ack_o = st_r.rack;
  assign refresh_data_o = st_r.rdata;
  assign step_dir_o = st_r.ctrl[`LRAP_CTRL_STEP_BIT];
  assign word_length_select_o = st_r.ctrl[`LRAP_CTRL_WLS_BIT];
  assign rmw_mode_o = st_r.ctrl[`LRAP_CTRL_RMW_BIT];

  // Index write captures the bus value at strobe end.
  property p_index_load;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (acc_end && st_r.is_wr && !rs_s) |=> (st_r.index == $past(data_s));
  endproperty
  a_index_load: assert property (p_index_load) else $error("index not loaded"); // R1

  // Index holds across data accesses.
  property p_index_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
      !(acc_end && st_r.is_wr && !rs_s) |=> $stable(st_r.index);
  endproperty
  a_index_hold: assert property (p_index_hold) else $error("index changed"); // R3

  // Row steps by one in row direction.
  property p_row_step;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (step && !st_r.ctrl[0] && st_r.row != 7'h7f) |=> (st_r.row == $past(st_r.row) + 7'h01);
  endproperty
  a_row_step: assert property (p_row_step) else $error("row step wrong"); // R10

  // Column stays fixed in row direction.
  property p_col_fixed;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (step && !st_r.ctrl[0]) |=> $stable(st_r.col);
  endproperty
  a_col_fixed: assert property (p_col_fixed) else $error("column moved"); // R10

  // Column wraps at its limit.
  property p_col_wrap;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (step && st_r.ctrl[0] && st_r.col == col_lim(st_r.ctrl[1])) |=> (st_r.col == 6'h00);
  endproperty
  a_col_wrap: assert property (p_col_wrap) else $error("column did not wrap"); // R13

  // Row stays fixed in column direction.
  property p_row_fixed;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (step && st_r.ctrl[0]) |=> $stable(st_r.row);
  endproperty
  a_row_fixed: assert property (p_row_fixed) else $error("row moved"); // R12

  // Read in RMW mode leaves pointers alone.
  property p_rmw_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (acc_end && !st_r.is_wr && win_sel && st_r.ctrl[2]) |=> ($stable(st_r.row) && $stable(st_r.col));
  endproperty
  a_rmw_hold: assert property (p_rmw_hold) else $error("pointer moved in rmw"); // R17

  // Refresh never granted in a host RAM cycle.
  property p_refresh_yield;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (host_ram_use) |=> !st_r.rack;
  endproperty
  a_refresh_yield: assert property (p_refresh_yield) else $error("refresh overrode host"); // R14

  // Column steps by one below its limit in column direction.
  property p_col_step;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (step && st_r.ctrl[0] && st_r.col < col_lim(st_r.ctrl[1])) |=>
        (st_r.col == $past(st_r.col) + 6'h01);
  endproperty
  a_col_step: assert property (p_col_step) else $error("column step wrong"); // R12

  // Row returns to zero after its top value.
  property p_row_wrap;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (step && !st_r.ctrl[0] && st_r.row == 7'h7f) |=> (st_r.row == 7'h00);
  endproperty
  a_row_wrap: assert property (p_row_wrap) else $error("row did not wrap"); // R10

  // A window read presents the byte latched by the read before it.
  property p_dout_latch;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (st_r.phase == LRAP_IDLE && act_s && wr_n_s && win_sel) |=>
        (host_data_o == $past(st_r.latch));
  endproperty
  a_dout_latch: assert property (p_dout_latch) else $error("read data not from latch"); // R8

  // A window read of a missing row latches zero.
  property p_latch_void;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (acc_end && !st_r.is_wr && win_sel && !ram_ok(st_r.col, st_r.row)) |=>
        (st_r.latch == 8'h00);
  endproperty
  a_latch_void: assert property (p_latch_void) else $error("missing row read not zero"); // R11

  // A host window write stores the masked byte at the pointed location.
  property p_ram_write;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (host_ram_use && ram_ok(st_r.col, st_r.row)) |=>
        (mem_r[$past(ram_idx(st_r.col, st_r.row))] == $past(wdata));
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("window write not stored"); // R19

  // A control register write takes the low three bits.
  property p_ctrl_write;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (acc_end && st_r.is_wr && rs_s && st_r.index == `LRAP_IDX_CTRL) |=>
        (st_r.ctrl == $past(data_s[2:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R22

  // A refresh request outside a host RAM cycle is answered next cycle.
  property p_refresh_grant;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (refresh_req_i && !host_ram_use) |=> refresh_ack_o;
  endproperty
  a_refresh_grant: assert property (p_refresh_grant) else $error("refresh not answered"); // R14
endmodule // lrap_host_port

/* lrap_params.svh */
// Constants for the LCD RAM host access port: register numbers, field positions, limits.
// Included by the host port module and by the bench; definitions only.
`ifndef LRAP_PARAMS_SVH
`define LRAP_PARAMS_SVH
// Data register numbers written into the index register.
`define LRAP_IDX_CTRL 8'h01
`define LRAP_IDX_COL 8'h02
`define LRAP_IDX_ROW 8'h03
`define LRAP_IDX_WIN 8'h04
// Control register field positions.
`define LRAP_CTRL_STEP_BIT 0
`define LRAP_CTRL_WLS_BIT 1
`define LRAP_CTRL_RMW_BIT 2
// Address limits and reset values.
`define LRAP_ROW_MAX 7'h7f
`define LRAP_ROW_VALID_MAX 7'h4f
`define LRAP_COL_MAX_8BIT 6'h27
`define LRAP_COL_MAX_6BIT 6'h35
`define LRAP_COL_RESET 6'h00
`define LRAP_ROW_RESET 7'h00
`define LRAP_IDX_RESET 8'h00
`define LRAP_CTRL_RESET 3'h0
// Data lines kept in 6-bit word mode.
`define LRAP_MASK_6BIT 8'h3f
`endif

/* lrap_pkg.sv */
// Types shared by the LCD RAM host access port modules.
// Assumes lrap_params.svh is in the include path.
package lrap_pkg;
  // Host access phase as seen by the core clock.
  typedef enum logic [1:0] {
    LRAP_IDLE,
    LRAP_ACT
  } lrap_phase_t;
endpackage

/* lrap_sync3.sv */
// Three-stage synchroniser with agreement filter for the asynchronous host pins.
// Assumes a single core clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module lrap_sync3 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Raw pin level and filtered level.
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  // All state in one packed struct.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } lrap_sync_t;
  lrap_sync_t st_r;
  lrap_sync_t st_nxt;

  // The first stage feeds only the second; a change is taken once stages two and three agree.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.lvl;
endmodule // lrap_sync3

/* tb.sv */
// Self-checking bench for the LCD RAM host access port.
// Assumes the host model paces strobes and the design files carry their own assertions.
`timescale 1ns/10ps
`include "lrap_params.svh"
module tb;
  import lrap_pkg::*;
  // Clock, reset and pins.
  logic core_clk_i, nrst_i, cs_n, rs, wr_n, rd_n, oe, ref_req, ref_ack;
  logic [7:0] din, dout, ref_data, d;
  logic [6:0] ref_row;
  logic [5:0] ref_col;
  logic [2:0] ctrl;
  logic oe_seen;
  int miscompares, checks_done, gaps;
  assign ctrl = {i_dut.rmw_mode_o, i_dut.word_length_select_o, i_dut.step_dir_o};

  lrap_host_port i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n),
    .register_select_i(rs), .wr_n_i(wr_n), .rd_n_i(rd_n), .host_data_i(din),
    .host_data_o(dout), .host_data_oe_o(oe), .refresh_req_i(ref_req),
    .refresh_row_i(ref_row), .refresh_col_i(ref_col), .refresh_ack_o(ref_ack),
    .refresh_data_o(ref_data), .step_dir_o(), .word_length_select_o(),
    .rmw_mode_o());
  lrap_host_model i_host (.core_clk_i(core_clk_i), .cs_n_o(cs_n), .register_select_o(rs),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .host_data_o(din), .host_data_i(dout),
    .host_data_oe_i(oe));

  // Free-running core clock at 125 MHz.
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Count every comparison and report a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Closing verdict, reached from the main sequence or the watchdog.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Index write, then data write to the register it names.
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    logic [7:0] x;
    logic e;
    i_host.access(1'b0, 1'b0, idx, x, e);
    i_host.access(1'b1, 1'b0, val, x, e);
  endtask

  // Window data accesses; the index must already name the window.
  task automatic win_wr(input logic [7:0] val);
    logic [7:0] x;
    logic e;
    i_host.access(1'b1, 1'b0, val, x, e);
  endtask
  task automatic win_rd(output logic [7:0] val);
    logic e;
    i_host.access(1'b1, 1'b1, 8'h00, val, e);
    check({7'h00, e}, 8'h01);
  endtask

  // Load both pointers, then leave the index on the window.
  task automatic seek(input logic [5:0] c, input logic [6:0] r);
    logic [7:0] x;
    logic e;
    reg_wr(`LRAP_IDX_COL, {2'h0, c});
    reg_wr(`LRAP_IDX_ROW, {1'h0, r});
    i_host.access(1'b0, 1'b0, `LRAP_IDX_WIN, x, e);
  endtask

  // Read one location: the first read only fills the latch.
  task automatic peek(input logic [5:0] c, input logic [6:0] r, input logic [7:0] exp);
    logic [7:0] v;
    seek(c, r);
    win_rd(v);
    win_rd(v);
    check(v, exp);
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial begin
    #200us;
    miscompares++;
    report_and_stop();
  end

  initial begin
    miscompares = 0;
    checks_done = 0;
    nrst_i = 1'b0;
    ref_req = 1'b0;
    ref_row = 7'h00;
    ref_col = 6'h00;
    repeat (20) @(negedge core_clk_i);
    nrst_i = 1'b1;
    check({5'h0, ctrl}, 8'h00);
    check(dout, 8'h00);
    // Control bits and a repeated data write without a new index.
    reg_wr(`LRAP_IDX_CTRL, 8'h07);
    check({5'h0, ctrl}, 8'h07);
    win_wr(8'h00);
    check({5'h0, ctrl}, 8'h00);
    i_host.access(1'b0, 1'b0, `LRAP_IDX_COL, d, oe_seen);
    i_host.access(1'b1, 1'b1, 8'h00, d, oe_seen);
    check({7'h00, oe_seen}, 8'h00);
    $display("test control done");
    // Row stepping with reads and writes both advancing.
    seek(6'h05, 7'h00);
    win_wr(8'hc3);
    win_wr(8'h5a);
    win_wr(8'h96);
    seek(6'h05, 7'h00);
    win_rd(d);
    win_rd(d);
    check(d, 8'hc3);
    win_rd(d);
    check(d, 8'h5a);
    win_rd(d);
    check(d, 8'h96);
    $display("test row step done");
    // Rows past the real memory are ignored and the row wraps after its top.
    seek(6'h05, 7'h4f);
    win_wr(8'h11);
    win_wr(8'h22);
    peek(6'h05, 7'h50, 8'h00);
    seek(6'h05, 7'h7f);
    win_wr(8'h77);
    win_wr(8'h33);
    peek(6'h05, 7'h00, 8'h33);
    peek(6'h05, 7'h4f, 8'h11);
    $display("test row limits done");
    // Column stepping wraps at the limit chosen by word length.
    reg_wr(`LRAP_IDX_CTRL, 8'h01);
    seek(6'h27, 7'h01);
    win_wr(8'he7);
    win_wr(8'h42);
    peek(6'h00, 7'h01, 8'h42);
    peek(6'h27, 7'h01, 8'he7);
    reg_wr(`LRAP_IDX_CTRL, 8'h03);
    seek(6'h35, 7'h01);
    win_wr(8'hff);
    win_wr(8'h12);
    peek(6'h35, 7'h01, 8'h3f);
    peek(6'h00, 7'h01, 8'h12);
    $display("test column step done");
    // Read-modify-write keeps the pointer after a read only.
    reg_wr(`LRAP_IDX_CTRL, 8'h04);
    seek(6'h02, 7'h0a);
    win_wr(8'h5a);
    seek(6'h02, 7'h0a);
    win_rd(d);
    win_rd(d);
    check(d, 8'h5a);
    win_wr(8'ha5);
    reg_wr(`LRAP_IDX_CTRL, 8'h00);
    peek(6'h02, 7'h0a, 8'ha5);
    $display("test rmw done");
    // A window write takes the RAM for exactly one cycle; refresh yields it there.
    seek(6'h03, 7'h02);
    @(negedge core_clk_i);
    ref_req = 1'b1;
    ref_row = 7'h02;
    ref_col = 6'h03;
    gaps = 0;
    fork
      win_wr(8'h6c);
      repeat (40) begin
        @(negedge core_clk_i);
        if (!ref_ack) begin
          gaps++;
        end
      end
    join
    check(gaps[7:0], 8'h01);
    check(ref_data, 8'h6c);
    // Back-to-back refresh reads, answered one cycle later.
    @(negedge core_clk_i);
    ref_req = 1'b1;
    ref_row = 7'h01;
    ref_col = 6'h00;
    @(negedge core_clk_i);
    check({7'h00, ref_ack}, 8'h01);
    check(ref_data, 8'h12);
    ref_row = 7'h00;
    ref_col = 6'h05;
    @(negedge core_clk_i);
    check({7'h00, ref_ack}, 8'h01);
    check(ref_data, 8'h33);
    ref_req = 1'b0;
    @(negedge core_clk_i);
    check({7'h00, ref_ack}, 8'h00);
    $display("test refresh done");
    report_and_stop();
  end
endmodule // tb
